//--- hw/dpram_top.sv
// synchronous dual-port ram: two independent burst ports plus an apb register slave
// assumes port pins are asynchronous to the core clock and each port clock is
// at most a quarter of the core rate; pins hold at least two core cycles
//
// Overview of operation
// - strobe low at a port edge loads burst counter from address pins.
// - port selected only when low-active select low and high-active select high.
// - port clock may run or be gated; act only on its rising edges.
// - count-step low advances burst counter by one each port rising edge.
// - count-step ignored whenever strobe or counter-clear is sampled low.
// - counter-clear low sets the burst counter to zero.
// - counter-clear wins over strobe and count-step in the same cycle.
// - lower lane select low enables low lane; 9 or 8 bits wide.
// - read data drives a lane only with lane select and output enable low.
// - upper lane select controls the upper lane the same way.
// - data pins driven only while output enable low, else high impedance.
// - write control low writes the array, high reads it.
// - latency select pin picks flow-through when low, pipelined when high.
// - pipelined reads pass an output register; flow-through bypasses it.
// - controls, address and write data captured on the owning port's edge.
// - depth 16K, 32K or 64K; both ports access all words independently.
// - array write is self-timed, independent of port clock phase lengths.
// - a deselected port cycle puts the port into low power.
// - pipelined outputs return only after one full selected cycle.
// - while counting each cycle accesses the next successive word.
// - burst counter spans the whole array and wraps to zero.
// - output enable acts asynchronously; latency select acts without a port edge; other inputs only at port edges.
// - deselected port's outputs go high impedance after its next edge (flow-through) or the edge after that (pipelined).
`timescale 1ns/1ps
`default_nettype none

module dpram_top
  import dpram_pkg::*;
(
  // core clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // left port
  input wire logic L_CLK_I,
  input wire logic [ADDR_W-1:0] L_ADDR_I,
  input wire logic L_ADDRESS_STROBE_N_I,
  input wire logic L_CHIP_SEL_LOW_ACTIVE_I,
  input wire logic L_CHIP_SEL_HIGH_ACTIVE_I,
  input wire logic L_COUNT_STEP_N_I,
  input wire logic L_COUNT_CLEAR_N_I,
  input wire logic L_LOWER_LANE_SEL_N_I,
  input wire logic L_UPPER_LANE_SEL_N_I,
  input wire logic L_WRITE_N_I,
  input wire logic L_OUT_EN_N_I,
  input wire logic L_OUTPUT_LATENCY_SEL_I,
  input wire logic [DATA_W-1:0] L_DQ_I,
  output logic [DATA_W-1:0] L_DQ_O,
  output logic [DATA_W-1:0] L_DQ_OE_N_O,
  // right port
  input wire logic R_CLK_I,
  input wire logic [ADDR_W-1:0] R_ADDR_I,
  input wire logic R_ADDRESS_STROBE_N_I,
  input wire logic R_CHIP_SEL_LOW_ACTIVE_I,
  input wire logic R_CHIP_SEL_HIGH_ACTIVE_I,
  input wire logic R_COUNT_STEP_N_I,
  input wire logic R_COUNT_CLEAR_N_I,
  input wire logic R_LOWER_LANE_SEL_N_I,
  input wire logic R_UPPER_LANE_SEL_N_I,
  input wire logic R_WRITE_N_I,
  input wire logic R_OUT_EN_N_I,
  input wire logic R_OUTPUT_LATENCY_SEL_I,
  input wire logic [DATA_W-1:0] R_DQ_I,
  output logic [DATA_W-1:0] R_DQ_O,
  output logic [DATA_W-1:0] R_DQ_OE_N_O
);

  logic [CFG_W-1:0] cfg_r;
  logic [31:0] prdata_r;
  logic [ADDR_W-1:0] addr_mask;
  logic [DATA_W-1:0] lo_lane;
  logic [DATA_W-1:0] up_lane;

  port_in_t raw [2];
  port_in_t s1_r [2];
  port_in_t s2_r [2];
  logic clk_d_r [2];
  logic rise [2];
  logic sel [2];
  logic [ADDR_W-1:0] cnt_r [2];
  logic [ADDR_W-1:0] cnt_nxt [2];
  logic mem_we [2];
  logic mem_re [2];
  logic [DATA_W-1:0] mem_mask [2];
  logic [DATA_W-1:0] mem_rdata [2];
  logic rd_pend_r [2];
  logic [DATA_W-1:0] rd_lanes_r [2];
  logic [DATA_W-1:0] ft_data_r [2];
  logic [DATA_W-1:0] ft_lanes_r [2];
  logic ft_act_r [2];
  logic [DATA_W-1:0] pipe_data_r [2];
  logic [DATA_W-1:0] pipe_lanes_r [2];
  logic pipe_act_r [2];
  logic pd_r [2];
  logic act [2];
  logic [DATA_W-1:0] dout [2];
  logic [DATA_W-1:0] drive [2];
  logic oe_n_pin [2];

  always_comb
  begin
    unique case (cfg_r[CFG_DEPTH_LSB +: 2])
      DEPTH_16K: addr_mask = MASK_16K;
      DEPTH_32K: addr_mask = MASK_32K;
      default: addr_mask = MASK_64K;
    endcase
  end

  assign lo_lane = cfg_r[CFG_WIDE_BIT] ? LO_LANE_18 : LO_LANE_16;
  assign up_lane = cfg_r[CFG_WIDE_BIT] ? UP_LANE_18 : UP_LANE_16;

  assign raw[0] = '{clk: L_CLK_I, addr: L_ADDR_I, address_strobe_n: L_ADDRESS_STROBE_N_I,
    chip_sel_low_active: L_CHIP_SEL_LOW_ACTIVE_I, chip_sel_high_active: L_CHIP_SEL_HIGH_ACTIVE_I,
    count_step_n: L_COUNT_STEP_N_I, count_clear_n: L_COUNT_CLEAR_N_I,
    lower_lane_sel_n: L_LOWER_LANE_SEL_N_I, upper_lane_sel_n: L_UPPER_LANE_SEL_N_I,
    write_n: L_WRITE_N_I, wdata: L_DQ_I, output_latency_sel: L_OUTPUT_LATENCY_SEL_I};
  assign raw[1] = '{clk: R_CLK_I, addr: R_ADDR_I, address_strobe_n: R_ADDRESS_STROBE_N_I,
    chip_sel_low_active: R_CHIP_SEL_LOW_ACTIVE_I, chip_sel_high_active: R_CHIP_SEL_HIGH_ACTIVE_I,
    count_step_n: R_COUNT_STEP_N_I, count_clear_n: R_COUNT_CLEAR_N_I,
    lower_lane_sel_n: R_LOWER_LANE_SEL_N_I, upper_lane_sel_n: R_UPPER_LANE_SEL_N_I,
    write_n: R_WRITE_N_I, wdata: R_DQ_I, output_latency_sel: R_OUTPUT_LATENCY_SEL_I};
  // output enable stays unsynchronised so it acts without any clock
  assign oe_n_pin[0] = L_OUT_EN_N_I;
  assign oe_n_pin[1] = R_OUT_EN_N_I;

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    // clock and pins share one two-stage path so their alignment is kept
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        s1_r[p] <= '0;
        s2_r[p] <= '0;
        clk_d_r[p] <= 1'b0;
      end
      else
      begin
        s1_r[p] <= raw[p];
        s2_r[p] <= s1_r[p];
        clk_d_r[p] <= s2_r[p].clk;
      end
    end

    assign rise[p] = s2_r[p].clk & ~clk_d_r[p];
    assign sel[p] = ~s2_r[p].chip_sel_low_active & s2_r[p].chip_sel_high_active;

    always_comb
    begin
      if (!s2_r[p].count_clear_n)
      begin
        cnt_nxt[p] = '0;
      end
      else if (!s2_r[p].address_strobe_n)
      begin
        cnt_nxt[p] = s2_r[p].addr & addr_mask;
      end
      else if (!s2_r[p].count_step_n)
      begin
        cnt_nxt[p] = (cnt_r[p] + 16'h0001) & addr_mask;
      end
      else
      begin
        cnt_nxt[p] = cnt_r[p];
      end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        cnt_r[p] <= '0;
      end
      else if (rise[p])
      begin
        cnt_r[p] <= cnt_nxt[p];
      end
    end

    assign mem_we[p] = rise[p] & sel[p] & ~s2_r[p].write_n;
    assign mem_re[p] = rise[p] & sel[p] & s2_r[p].write_n;
    assign mem_mask[p] = (s2_r[p].lower_lane_sel_n ? '0 : lo_lane)
      | (s2_r[p].upper_lane_sel_n ? '0 : up_lane);

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        rd_pend_r[p] <= 1'b0;
        rd_lanes_r[p] <= '0;
        pd_r[p] <= 1'b0;
      end
      else
      begin
        rd_pend_r[p] <= mem_re[p];
        if (rise[p])
        begin
          rd_lanes_r[p] <= mem_mask[p];
          pd_r[p] <= ~sel[p];
        end
      end
    end

    // write or deselect ends the flow-through drive
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        ft_data_r[p] <= '0;
        ft_lanes_r[p] <= '0;
        ft_act_r[p] <= 1'b0;
      end
      else if (rd_pend_r[p])
      begin
        ft_data_r[p] <= mem_rdata[p];
        ft_lanes_r[p] <= rd_lanes_r[p];
        ft_act_r[p] <= 1'b1;
      end
      else if (rise[p])
      begin
        ft_act_r[p] <= 1'b0;
      end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        pipe_data_r[p] <= '0;
        pipe_lanes_r[p] <= '0;
        pipe_act_r[p] <= 1'b0;
      end
      else if (rise[p])
      begin
        pipe_data_r[p] <= ft_data_r[p];
        pipe_lanes_r[p] <= ft_lanes_r[p];
        pipe_act_r[p] <= ft_act_r[p];
      end
    end

    assign act[p] = s2_r[p].output_latency_sel ? pipe_act_r[p] : ft_act_r[p];
    assign dout[p] = s2_r[p].output_latency_sel ? pipe_data_r[p] : ft_data_r[p];
    assign drive[p] = (s2_r[p].output_latency_sel ? pipe_lanes_r[p] : ft_lanes_r[p])
      & {DATA_W{act[p] & ~oe_n_pin[p]}};

    sequence s_ft_read;
      rise[p] && sel[p] && s2_r[p].write_n && !s2_r[p].output_latency_sel;
    endsequence

    sequence s_ft_shown;
      ##2 ft_act_r[p] && ft_data_r[p] == $past(mem_rdata[p]);
    endsequence

    AST_CLEAR_WINS:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      rise[p] && !s2_r[p].count_clear_n |=> cnt_r[p] == '0)
      else $error("counter not cleared");

    AST_LOAD_ADDR:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      rise[p] && s2_r[p].count_clear_n && !s2_r[p].address_strobe_n
      |=> cnt_r[p] == ($past(s2_r[p].addr) & addr_mask))
      else $error("counter not loaded from address");

    AST_STEP_WRAP:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      rise[p] && s2_r[p].count_clear_n && s2_r[p].address_strobe_n
      && !s2_r[p].count_step_n && cnt_r[p] == addr_mask |=> cnt_r[p] == '0)
      else $error("counter did not wrap");

    AST_STEP_ONE:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      rise[p] && s2_r[p].count_clear_n && s2_r[p].address_strobe_n
      && !s2_r[p].count_step_n |=> cnt_r[p] == (($past(cnt_r[p]) + 16'h0001) & addr_mask))
      else $error("counter did not step by one");

    AST_NO_EDGE_HOLD:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !rise[p] |=> $stable(cnt_r[p]))
      else $error("counter moved without port edge");

    AST_OE_GATES:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      oe_n_pin[p] |-> drive[p] == '0)
      else $error("data driven with output enable high");

    AST_FT_LATENCY:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_ft_read |-> s_ft_shown)
      else $error("flow-through data late");

    AST_DESEL_HIZ:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      rise[p] && !sel[p] && !s2_r[p].output_latency_sel |=> !act[p] [*2])
      else $error("outputs active after deselect");

    AST_PIPE_LAG:
    assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      $rose(pipe_act_r[p]) |-> $past(rise[p]) && $past(ft_act_r[p]))
      else $error("pipelined drive without prior read");
  end

  dpram_array u_array (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .a_we_i(mem_we[0]),
    .a_re_i(mem_re[0]),
    .a_addr_i(cnt_nxt[0]),
    .a_mask_i(mem_mask[0]),
    .a_wdata_i(s2_r[0].wdata),
    .a_rdata_o(mem_rdata[0]),
    .b_we_i(mem_we[1]),
    .b_re_i(mem_re[1]),
    .b_addr_i(cnt_nxt[1]),
    .b_mask_i(mem_mask[1]),
    .b_wdata_i(s2_r[1].wdata),
    .b_rdata_o(mem_rdata[1])
  );

  assign L_DQ_O = dout[0];
  assign R_DQ_O = dout[1];
  assign L_DQ_OE_N_O = ~drive[0];
  assign R_DQ_OE_N_O = ~drive[1];

  // apb: zero wait states, read data registered in the setup cycle
  assign PREADY_O = 1'b1;
  assign PRDATA_O = prdata_r;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~(PADDR_I == CFG_OFS || PADDR_I == STAT_OFS
    || PADDR_I == CNT_L_OFS || PADDR_I == CNT_R_OFS);

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cfg_r <= CFG_RST;
    end
    else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == CFG_OFS)
    begin
      cfg_r <= PWDATA_I[CFG_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prdata_r <= '0;
    end
    else if (PSEL_I && !PENABLE_I)
    begin
      prdata_r <= '0;
      unique case (PADDR_I)
        CFG_OFS: prdata_r[CFG_W-1:0] <= cfg_r;
        STAT_OFS:
        begin
          prdata_r[STAT_PD_LSB +: 2] <= {pd_r[1], pd_r[0]};
          prdata_r[STAT_ACT_LSB +: 2] <= {act[1], act[0]};
          prdata_r[STAT_PIPE_LSB +: 2] <= {s2_r[1].output_latency_sel,
            s2_r[0].output_latency_sel};
        end
        CNT_L_OFS: prdata_r[ADDR_W-1:0] <= cnt_r[0];
        CNT_R_OFS: prdata_r[ADDR_W-1:0] <= cnt_r[1];
        default: prdata_r <= '0;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- hw/dpram_pkg.sv
// constants and types shared by the dual-port ram port logic and its array
// assumes one core clock; port clocks arrive as sampled pins
package dpram_pkg;

  localparam int DATA_W = 18;
  localparam int ADDR_W = 16;
  localparam int DEPTH = 65536;
  localparam int APB_AW = 12;

  // register offsets (byte addresses)
  localparam logic [APB_AW-1:0] CFG_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
  localparam logic [APB_AW-1:0] CNT_L_OFS = 12'h008;
  localparam logic [APB_AW-1:0] CNT_R_OFS = 12'h00c;

  // configuration fields
  localparam int CFG_DEPTH_LSB = 0;
  localparam int CFG_WIDE_BIT = 2;
  localparam int CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h6;

  // status fields
  localparam int STAT_PD_LSB = 0;
  localparam int STAT_ACT_LSB = 2;
  localparam int STAT_PIPE_LSB = 4;

  // array depth variants
  localparam logic [1:0] DEPTH_16K = 2'h0;
  localparam logic [1:0] DEPTH_32K = 2'h1;
  localparam logic [ADDR_W-1:0] MASK_16K = 16'h3fff;
  localparam logic [ADDR_W-1:0] MASK_32K = 16'h7fff;
  localparam logic [ADDR_W-1:0] MASK_64K = 16'hffff;

  // byte lanes for the 18-bit and 16-bit organisations
  localparam logic [DATA_W-1:0] LO_LANE_18 = 18'h0_01ff;
  localparam logic [DATA_W-1:0] UP_LANE_18 = 18'h3_fe00;
  localparam logic [DATA_W-1:0] LO_LANE_16 = 18'h0_00ff;
  localparam logic [DATA_W-1:0] UP_LANE_16 = 18'h0_ff00;

  // one port's synchronous pins, sampled together
  typedef struct packed {
    logic clk;
    logic [ADDR_W-1:0] addr;
    logic address_strobe_n;
    logic chip_sel_low_active;
    logic chip_sel_high_active;
    logic count_step_n;
    logic count_clear_n;
    logic lower_lane_sel_n;
    logic upper_lane_sel_n;
    logic write_n;
    logic [DATA_W-1:0] wdata;
    logic output_latency_sel;
  } port_in_t;

endpackage

//--- hw/dpram_array.sv
// two-port storage array with bit-masked writes and registered read data
// assumes both ports run on the core clock; same-address writes: port b wins
`timescale 1ns/1ps
`default_nettype none

module dpram_array
  import dpram_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // port a
  input wire logic a_we_i,
  input wire logic a_re_i,
  input wire logic [ADDR_W-1:0] a_addr_i,
  input wire logic [DATA_W-1:0] a_mask_i,
  input wire logic [DATA_W-1:0] a_wdata_i,
  output logic [DATA_W-1:0] a_rdata_o,
  // port b
  input wire logic b_we_i,
  input wire logic b_re_i,
  input wire logic [ADDR_W-1:0] b_addr_i,
  input wire logic [DATA_W-1:0] b_mask_i,
  input wire logic [DATA_W-1:0] b_wdata_i,
  output logic [DATA_W-1:0] b_rdata_o
);

  logic [DATA_W-1:0] mem [DEPTH];

  // write completes in one core cycle, independent of port clock phases
  always_ff @(posedge clk_i)
  begin
    if (a_we_i)
    begin
      mem[a_addr_i] <= (mem[a_addr_i] & ~a_mask_i) | (a_wdata_i & a_mask_i);
    end
    if (b_we_i)
    begin
      mem[b_addr_i] <= (mem[b_addr_i] & ~b_mask_i) | (b_wdata_i & b_mask_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      a_rdata_o <= '0;
    end
    else if (a_re_i)
    begin
      a_rdata_o <= mem[a_addr_i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      b_rdata_o <= '0;
    end
    else if (b_re_i)
    begin
      b_rdata_o <= mem[b_addr_i];
    end
  end

endmodule

`default_nettype wire

//--- bench/port_host.sv
// host model for one ram port: drives pins paced by the core clock
// assumes the port samples pins about three core cycles after a clock rise
`timescale 1ns/1ps
`default_nettype none

module port_host
  import dpram_pkg::*;
(
  // pacing clock
  input wire logic clk_i,
  // port pins
  output var port_in_t pin_o,
  output var logic out_en_n_o,
  // device side of the data pins
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic [DATA_W-1:0] dq_oe_n_i
);
  port_in_t pv;
  logic drv;
  logic [DATA_W-1:0] hd;
  logic [DATA_W-1:0] idle;

  initial
  begin
    pv = '0;
    drv = 1'b0;
    hd = '0;
    idle = 18'h2_aaaa;
    out_en_n_o = 1'b0;
  end

  // released lines show a changing pattern, never the last value
  always @(posedge clk_i)
    idle <= ~idle;

  always_comb
  begin
    pin_o = pv;
    pin_o.wdata = (~dq_oe_n_i & dq_i) | (dq_oe_n_i & (drv ? hd : idle));
  end

  // one port clock cycle; the clock stands low between calls
  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [7:0] c,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                     output logic [DATA_W-1:0] qoe);
    begin
      @(posedge clk_i);
      pv.addr <= a;
      {pv.address_strobe_n, pv.count_step_n, pv.count_clear_n, pv.write_n,
       pv.chip_sel_low_active, pv.chip_sel_high_active, pv.lower_lane_sel_n,
       pv.upper_lane_sel_n} <= c;
      hd <= d;
      drv <= ~c[4];
      repeat (4) @(posedge clk_i);
      pv.clk <= 1'b1;
      repeat (4) @(posedge clk_i);
      pv.clk <= 1'b0;
      drv <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      q = dq_i;
      qoe = dq_oe_n_i;
    end
  endtask

  task automatic pins(input logic oe_n, input logic lat);
    begin
      @(posedge clk_i);
      out_en_n_o <= oe_n;
      pv.output_latency_sel <= lat;
    end
  endtask
endmodule

`default_nettype wire

//--- bench/tb.sv
// bench for the dual-port ram: apb master plus one host model per port
// assumes the apb slave may insert wait states; ports share pacing
`timescale 1ns/1ps
`default_nettype none

module tb
  import dpram_pkg::*;
;
  localparam logic [7:0] LD_WR = 8'h64, LD_RD = 8'h74, ST_WR = 8'ha4, ST_RD = 8'hb4;
  localparam logic [7:0] DESEL = 8'hfc, CLR = 8'h14, LD_ST = 8'h34;
  localparam logic [DATA_W-1:0] BOTH = LO_LANE_18 | UP_LANE_18;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, loe, roe;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] ldq, loen, rdq, roen, q, qoe, q2, qoe2, v;
  logic [ADDR_W-1:0] tops [3];
  port_in_t lp, rp;
  int fail_count = 0;
  int num_checks = 0;
  int cyc_n = 0;

  port_host hl (.clk_i(clk), .pin_o(lp), .out_en_n_o(loe), .dq_i(ldq), .dq_oe_n_i(loen));
  port_host hr (.clk_i(clk), .pin_o(rp), .out_en_n_o(roe), .dq_i(rdq), .dq_oe_n_i(roen));

  dpram_top DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr),
    .L_CLK_I(lp.clk), .L_ADDR_I(lp.addr), .L_ADDRESS_STROBE_N_I(lp.address_strobe_n),
    .L_CHIP_SEL_LOW_ACTIVE_I(lp.chip_sel_low_active),
    .L_CHIP_SEL_HIGH_ACTIVE_I(lp.chip_sel_high_active), .L_COUNT_STEP_N_I(lp.count_step_n),
    .L_COUNT_CLEAR_N_I(lp.count_clear_n), .L_LOWER_LANE_SEL_N_I(lp.lower_lane_sel_n),
    .L_UPPER_LANE_SEL_N_I(lp.upper_lane_sel_n), .L_WRITE_N_I(lp.write_n),
    .L_OUT_EN_N_I(loe), .L_OUTPUT_LATENCY_SEL_I(lp.output_latency_sel),
    .L_DQ_I(lp.wdata), .L_DQ_O(ldq), .L_DQ_OE_N_O(loen),
    .R_CLK_I(rp.clk), .R_ADDR_I(rp.addr), .R_ADDRESS_STROBE_N_I(rp.address_strobe_n),
    .R_CHIP_SEL_LOW_ACTIVE_I(rp.chip_sel_low_active),
    .R_CHIP_SEL_HIGH_ACTIVE_I(rp.chip_sel_high_active), .R_COUNT_STEP_N_I(rp.count_step_n),
    .R_COUNT_CLEAR_N_I(rp.count_clear_n), .R_LOWER_LANE_SEL_N_I(rp.lower_lane_sel_n),
    .R_UPPER_LANE_SEL_N_I(rp.upper_lane_sel_n), .R_WRITE_N_I(rp.write_n),
    .R_OUT_EN_N_I(roe), .R_OUTPUT_LATENCY_SEL_I(rp.output_latency_sel),
    .R_DQ_I(rp.wdata), .R_DQ_O(rdq), .R_DQ_OE_N_O(roen)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // a hang costs one mismatch and ends the run
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    begin
      num_checks++;
      if (s !== e)
      begin
        fail_count++;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  // undriven lanes' data is masked so only driven bits' data is compared; every bit's output enable is compared
  task automatic chk_rd(input string nm, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] oe,
                        input logic [DATA_W-1:0] ed, input logic [DATA_W-1:0] em);
    chk(nm, {oe, d & ~oe}, {~em, ed & em});
  endtask

  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends this wait; answer taken at the ready edge
      do
        @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [APB_AW-1:0] a, input logic [31:0] e, input string nm);
    begin
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk(nm, {4'h0, rd}, {4'h0, e});
    end
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rst_n = 1'b0;
    tops = '{16'h3fff, 16'h7fff, 16'hffff};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(CFG_OFS, 32'h0000_0006, "cfg_reset");
    apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
    chk("unmapped_err", {35'h0, err}, 36'h1);
    // write a word on the left, then read it on the right while the left writes the next word
    hl.cyc(16'h0123, LD_WR, 18'h2_5a5a, q, qoe);
    // never the same word from both sides
    fork
      hl.cyc(16'h0124, LD_WR, 18'h1_1111, q, qoe);
      hr.cyc(16'h0123, LD_RD, '0, q2, qoe2);
    join
    chk_rd("xport", q2, qoe2, 18'h2_5a5a, BOTH);
    // burst with a stopped port clock between cycles
    hl.cyc(16'h0200, LD_WR, 18'h0_0100, q, qoe);
    for (int i = 1; i < 4; i++)
      hl.cyc('0, ST_WR, 18'h0_0100 + 18'(i), q, qoe);
    rchk(CNT_L_OFS, 32'h0000_0203, "cnt_step");
    hr.cyc(16'h0200, LD_RD, '0, q, qoe);
    chk_rd("burst0", q, qoe, 18'h0_0100, BOTH);
    for (int i = 1; i < 4; i++)
    begin
      hr.cyc('0, ST_RD, '0, q, qoe);
      chk_rd("burst", q, qoe, 18'h0_0100 + 18'(i), BOTH);
    end
    rchk(CNT_R_OFS, 32'h0000_0203, "cnt_r_step");
    hl.cyc(16'h0300, LD_ST, '0, q, qoe);
    rchk(CNT_L_OFS, 32'h0000_0300, "load_wins");
    hl.cyc(16'h0300, CLR, '0, q, qoe);
    rchk(CNT_L_OFS, 32'h0000_0000, "clear_wins");
    for (int d = 0; d < 3; d++)
    begin
      apb(1'b1, CFG_OFS, 32'h0000_0004 | 32'(d), rd, err);
      hl.cyc(tops[d], LD_RD, '0, q, qoe);
      hl.cyc('0, ST_RD, '0, q, qoe);
      rchk(CNT_L_OFS, 32'h0000_0000, "wrap");
    end
    // half-selected writes must not land
    hl.cyc(16'h0123, 8'h6c, 18'h3_ffff, q, qoe);
    hl.cyc(16'h0123, 8'h60, 18'h3_ffff, q, qoe);
    hr.cyc(16'h0123, LD_RD, '0, q, qoe);
    chk_rd("half_sel", q, qoe, 18'h2_5a5a, BOTH);
    fork
      hl.cyc('0, DESEL, '0, q, qoe);
      hr.cyc('0, DESEL, '0, q2, qoe2);
    join
    chk_rd("desel_off", q, qoe, '0, '0);
    chk_rd("desel_off_r", q2, qoe2, '0, '0);
    apb(1'b0, STAT_OFS, 32'h0000_0000, rd, err);
    chk("power_down", {30'h0, rd[5:0]}, 36'h0_0000_0003);
    // lower lane only written, then each lane read alone
    hl.cyc(16'h0123, LD_WR | 8'h01, 18'h0_00c3, q, qoe);
    v = (18'h2_5a5a & UP_LANE_18) | (18'h0_00c3 & LO_LANE_18);
    hl.cyc(16'h0123, LD_RD | 8'h02, '0, q, qoe);
    chk_rd("upper_only", q, qoe, v, UP_LANE_18);
    hl.cyc(16'h0123, LD_RD | 8'h01, '0, q, qoe);
    chk_rd("lower_only", q, qoe, v, LO_LANE_18);
    apb(1'b1, CFG_OFS, 32'h0000_0002, rd, err);
    hl.cyc(16'h0123, LD_RD, '0, q, qoe);
    chk_rd("narrow", q, qoe, v, LO_LANE_16 | UP_LANE_16);
    apb(1'b1, CFG_OFS, 32'h0000_0006, rd, err);
    // output enable must act inside one core cycle
    hl.cyc(16'h0123, LD_RD, '0, q, qoe);
    hl.pins(1'b1, 1'b0);
    #1;
    chk("oe_off", {loen, 18'h0_0000}, {18'h3_ffff, 18'h0_0000});
    hl.pins(1'b0, 1'b0);
    #1;
    chk_rd("oe_on", ldq, loen, v, BOTH);
    // pipelined: off after a deselect, then one cycle late
    hr.pins(1'b0, 1'b1);
    hr.cyc('0, DESEL, '0, q, qoe);
    hr.cyc(16'h0123, LD_RD, '0, q, qoe);
    chk_rd("pipe_first", q, qoe, '0, '0);
    hr.cyc(16'h0200, LD_RD, '0, q, qoe);
    chk_rd("pipe_late", q, qoe, v, BOTH);
    end_sim();
  end
endmodule

`default_nettype wire
